/* design/ppsd_consts.vh */
// Constants for the power-on phase position source decoder.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef PPSD_CONSTS_VH
`define PPSD_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define PPSD_OFF_PHASE_WORD 8'h00
`define PPSD_OFF_SERVO_PARAM 8'h04
`define PPSD_OFF_CFG 8'h08
`define PPSD_OFF_CMD 8'h0C
`define PPSD_OFF_STATUS 8'h10
`define PPSD_OFF_PHASE_POS 8'h14
`define PPSD_OFF_ABS_POS 8'h18

// ****************************************
// Reset values
// ****************************************
`define PPSD_RST_PHASE_WORD 24'h00_0000
`define PPSD_RST_SERVO_PARAM 24'h00_0000
`define PPSD_RST_CFG 12'h000

// ****************************************
// Configuration and command fields
// ****************************************
`define PPSD_CFG_SKIP_AUTO_BIT 2
`define PPSD_CFG_FMT_LSB 4
`define PPSD_CFG_FMT_MSB 5
`define PPSD_CFG_SLIP_BIT 8
`define PPSD_CMD_PHASE_BIT 0
`define PPSD_CMD_ABS_BIT 1
`define PPSD_FMT_HEX_A 2'h2
`define PPSD_FMT_HEX_B 2'h3

// ****************************************
// Fields of the source word
// ****************************************
`define PPSD_ADDR_MSB 15
`define PPSD_SEL_LSB 16
`define PPSD_SEL_MSB 23
`define PPSD_WIDTH_LSB 16
`define PPSD_WIDTH_MSB 21
`define PPSD_SPACE_BIT 22
`define PPSD_HALL_BIT 23
`define PPSD_HALL_LSB 20
`define PPSD_HALL_MSB 22
`define PPSD_WIDTH_MIN 6'h08
`define PPSD_WIDTH_MAX 6'h18
`define PPSD_SEL_MUX_MAX 8'h07
`define PPSD_SEL_RING_RD 8'h73
`define PPSD_SEL_RING_PAR 8'h74
`define PPSD_SEL_SPACE_MASK 8'hBF
`define PPSD_FULL_WORD 24'hFF_FFFF

// ****************************************
// Source kinds driven on the read port
// ****************************************
`define PPSD_SRC_NONE 3'h0
`define PPSD_SRC_MUX_RD 3'h1
`define PPSD_SRC_PAR_Y 3'h2
`define PPSD_SRC_PAR_X 3'h3
`define PPSD_SRC_RING_RD 3'h4
`define PPSD_SRC_RING_PAR 3'h5
`define PPSD_SRC_HALL 3'h6

// ****************************************
// AXI responses
// ****************************************
`define PPSD_RESP_OKAY 2'h0
`define PPSD_RESP_SLVERR 2'h2

`endif

/* design/ppsd_word_decode.v */
// Combinational decoder of one 24-bit source word into a read method.
// Assumes the word is stable from a register in the same clock domain.
`timescale 1ns/100ps
`default_nettype none

`include "ppsd_consts.vh"

module ppsd_word_decode (
	input wire [23:0] word,
	output reg [2:0] kind,
	output reg [15:0] addr,
	output reg [3:0] sub,
	output reg [5:0] width
);
	wire [7:0] sel = word[`PPSD_SEL_MSB:`PPSD_SEL_LSB];
	wire [7:0] sel_nospace = sel & `PPSD_SEL_SPACE_MASK;

	// ****************************************
	// Selector decode
	// ****************************************
	// Zero word and unknown selectors both mean no special read
	always @* begin
		kind = `PPSD_SRC_NONE;
		addr = word[`PPSD_ADDR_MSB:0];
		sub = 4'h0;
		width = word[`PPSD_WIDTH_MSB:`PPSD_WIDTH_LSB];
		if (word == 24'h00_0000) begin
			kind = `PPSD_SRC_NONE;
		end else if (word[`PPSD_HALL_BIT]) begin
			kind = `PPSD_SRC_HALL;
		end else if (sel <= `PPSD_SEL_MUX_MAX) begin
			// Port address in low byte, converter and bank in selector
			addr = {8'h00, word[7:0]};
			sub = {1'b0, sel[2:0]};
			if (word[2:0] == 3'h0 && word[15:8] == 8'h00) begin
				kind = `PPSD_SRC_MUX_RD;
			end else if (word[7:0] == 8'h00 && word[15:8] == 8'h01 && sel == 8'h00) begin
				// Converter 0 at port 0 is coded with bit 8 set
				kind = `PPSD_SRC_MUX_RD;
			end
		end else if (sel_nospace >= `PPSD_WIDTH_MIN && sel_nospace <= `PPSD_WIDTH_MAX) begin
			kind = word[`PPSD_SPACE_BIT] ? `PPSD_SRC_PAR_X : `PPSD_SRC_PAR_Y;
		end else if (sel == `PPSD_SEL_RING_RD) begin
			kind = `PPSD_SRC_RING_RD;
			sub = word[3:0];
		end else if (sel == `PPSD_SEL_RING_PAR) begin
			kind = `PPSD_SRC_RING_PAR;
			sub = word[3:0];
		end else begin
			kind = `PPSD_SRC_NONE;
		end
	end
endmodule

`default_nettype wire

/* design/ppsd_top.v */
// Power-on phase position source decoder with AXI4-Lite register access.
// Assumes a position-source read port in the same clock domain that answers
// each held request with a one-cycle acknowledge carrying 24 data bits.
`timescale 1ns/100ps
`default_nettype none

`include "ppsd_consts.vh"

module ppsd_top (
	input wire CORE_CLK,
	input wire RST_N,
	input wire [7:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [7:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	output reg SRC_REQ,
	output reg [2:0] SRC_KIND,
	output reg [15:0] SRC_ADDR,
	output reg [3:0] SRC_SUB,
	input wire SRC_ACK,
	input wire [23:0] SRC_DATA,
	output reg [23:0] PHASE_POS,
	output reg PHASE_VALID,
	output reg PHASE_SEARCH_REQ,
	output reg [23:0] ABS_POS,
	output reg ABS_VALID,
	output reg HEX_REPORT,
	output reg BUSY
);
	localparam S_IDLE = 2'h0, S_WAIT = 2'h1;

	// ****************************************
	// Helper functions
	// ****************************************
	// Byte-lane merge for AXI write strobes
	function [31:0] strb_merge;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] strb;
		integer i;
		begin
			strb_merge = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i]) begin
					strb_merge[i*8 +: 8] = new_val[i*8 +: 8];
				end
			end
		end
	endfunction

	// Shape raw source data by read method
	function [23:0] extract;
		input [2:0] kind;
		input [5:0] width;
		input [23:0] data;
		begin
			if (kind == `PPSD_SRC_HALL) begin
				extract = {21'h00_0000, data[`PPSD_HALL_MSB:`PPSD_HALL_LSB]};
			end else if (kind == `PPSD_SRC_PAR_X || kind == `PPSD_SRC_PAR_Y) begin
				extract = data & (`PPSD_FULL_WORD >> (6'd24 - width));
			end else begin
				extract = data;
			end
		end
	endfunction

	// ****************************************
	// Registers and decoders
	// ****************************************
	reg [23:0] phase_word_reg, servo_param_reg;
	reg [11:0] cfg_reg;
	reg [7:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	reg phase_cmd_reg, abs_cmd_reg, phase_pend_reg, abs_pend_reg, boot_reg, job_abs_reg;
	reg [1:0] state_reg;
	reg [5:0] job_width_reg;
	wire [2:0] ph_kind, sv_kind;
	wire [15:0] ph_addr, sv_addr;
	wire [3:0] ph_sub, sv_sub;
	wire [5:0] ph_width, sv_width;
	wire do_write, phase_take, abs_take, servo_positive;
	wire [1:0] fmt = cfg_reg[`PPSD_CFG_FMT_MSB:`PPSD_CFG_FMT_LSB];
	// Write data merged by strobes; each register keeps only its own width
	wire [31:0] mrg_phase = strb_merge({8'h00, phase_word_reg}, w_data_reg, w_strb_reg);
	wire [31:0] mrg_servo = strb_merge({8'h00, servo_param_reg}, w_data_reg, w_strb_reg);
	wire [31:0] mrg_cfg = strb_merge({20'h0_0000, cfg_reg}, w_data_reg, w_strb_reg);

	// Two decoders: phase read and servo position read use separate words
	ppsd_word_decode u_phase_dec (.word(phase_word_reg), .kind(ph_kind), .addr(ph_addr),
		.sub(ph_sub), .width(ph_width));

	ppsd_word_decode u_servo_dec (.word(servo_param_reg), .kind(sv_kind), .addr(sv_addr),
		.sub(sv_sub), .width(sv_width));

	assign do_write = ~S_AXI_AWREADY & ~S_AXI_WREADY & ~S_AXI_BVALID;
	assign servo_positive = (servo_param_reg != 24'h00_0000) & ~servo_param_reg[23];
	assign phase_take = (state_reg == S_IDLE) & ~boot_reg & phase_pend_reg;
	assign abs_take = (state_reg == S_IDLE) & ~boot_reg & ~phase_pend_reg & abs_pend_reg;

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	// Address and data are caught in either order; the write lands one cycle after both
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `PPSD_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			phase_word_reg <= `PPSD_RST_PHASE_WORD;
			servo_param_reg <= `PPSD_RST_SERVO_PARAM;
			cfg_reg <= `PPSD_RST_CFG;
			phase_cmd_reg <= 1'b0;
			abs_cmd_reg <= 1'b0;
		end else begin
			phase_cmd_reg <= 1'b0;
			abs_cmd_reg <= 1'b0;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_addr_reg <= S_AXI_AWADDR;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
				S_AXI_WREADY <= 1'b0;
			end
			if (do_write) begin
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= `PPSD_RESP_OKAY;
				case ({aw_addr_reg[7:2], 2'b00})
					`PPSD_OFF_PHASE_WORD: phase_word_reg <= mrg_phase[23:0];
					`PPSD_OFF_SERVO_PARAM: servo_param_reg <= mrg_servo[23:0];
					`PPSD_OFF_CFG: cfg_reg <= mrg_cfg[11:0];
					`PPSD_OFF_CMD: begin
						phase_cmd_reg <= w_strb_reg[0] & w_data_reg[`PPSD_CMD_PHASE_BIT];
						abs_cmd_reg <= w_strb_reg[0] & w_data_reg[`PPSD_CMD_ABS_BIT];
					end
					`PPSD_OFF_STATUS, `PPSD_OFF_PHASE_POS, `PPSD_OFF_ABS_POS: S_AXI_BRESP <= `PPSD_RESP_OKAY;
					default: S_AXI_BRESP <= `PPSD_RESP_SLVERR;
				endcase
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	// One read in flight; the answer follows the address handshake by one cycle
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `PPSD_RESP_OKAY;
		end else begin
			if (S_AXI_ARVALID && S_AXI_ARREADY) begin
				S_AXI_ARREADY <= 1'b0;
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= `PPSD_RESP_OKAY;
				S_AXI_RDATA <= 32'h0000_0000;
				case ({S_AXI_ARADDR[7:2], 2'b00})
					`PPSD_OFF_PHASE_WORD: S_AXI_RDATA <= {8'h00, phase_word_reg};
					`PPSD_OFF_SERVO_PARAM: S_AXI_RDATA <= {8'h00, servo_param_reg};
					`PPSD_OFF_CFG: S_AXI_RDATA <= {20'h0_0000, cfg_reg};
					`PPSD_OFF_CMD: S_AXI_RDATA <= 32'h0000_0000;
					`PPSD_OFF_STATUS: S_AXI_RDATA <= {21'h00_0000, ph_kind, 3'h0, HEX_REPORT,
						ABS_VALID, PHASE_SEARCH_REQ, PHASE_VALID, BUSY};
					`PPSD_OFF_PHASE_POS: S_AXI_RDATA <= {8'h00, PHASE_POS};
					`PPSD_OFF_ABS_POS: S_AXI_RDATA <= {8'h00, ABS_POS};
					default: S_AXI_RRESP <= `PPSD_RESP_SLVERR;
				endcase
			end
			if (S_AXI_RVALID && S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
				S_AXI_ARREADY <= 1'b1;
			end
		end
	end

	// ****************************************
	// Pending requests
	// ****************************************
	// A command landing in the cycle its pending flag is taken is kept, so set wins
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			boot_reg <= 1'b1;
			phase_pend_reg <= 1'b0;
			abs_pend_reg <= 1'b0;
		end else begin
			boot_reg <= 1'b0;
			// Power-up pass sees the parameter values present after reset
			phase_pend_reg <= (phase_pend_reg & ~phase_take) | phase_cmd_reg | boot_reg;
			abs_pend_reg <= (abs_pend_reg & ~abs_take) | abs_cmd_reg
				| (boot_reg & servo_positive & ~cfg_reg[`PPSD_CFG_SKIP_AUTO_BIT]);
		end
	end

	// ****************************************
	// Read sequencer
	// ****************************************
	// Phase read has priority; the request is held until the source acknowledges
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_reg <= S_IDLE;
			job_abs_reg <= 1'b0;
			job_width_reg <= 6'h00;
			SRC_REQ <= 1'b0;
			SRC_KIND <= `PPSD_SRC_NONE;
			SRC_ADDR <= 16'h0000;
			SRC_SUB <= 4'h0;
			PHASE_POS <= 24'h00_0000;
			PHASE_VALID <= 1'b0;
			PHASE_SEARCH_REQ <= 1'b0;
			ABS_POS <= 24'h00_0000;
			ABS_VALID <= 1'b0;
			BUSY <= 1'b0;
		end else begin
			case (state_reg)
				S_IDLE: begin
					if (boot_reg && !(servo_positive && !cfg_reg[`PPSD_CFG_SKIP_AUTO_BIT])) begin
						ABS_POS <= 24'h00_0000;
						ABS_VALID <= 1'b0;
					end
					if (phase_take) begin
						if (ph_kind == `PPSD_SRC_NONE) begin
							// No absolute phase: synchronous motors need a search
							PHASE_VALID <= 1'b0;
							PHASE_SEARCH_REQ <= ~cfg_reg[`PPSD_CFG_SLIP_BIT];
						end else begin
							state_reg <= S_WAIT;
							job_abs_reg <= 1'b0;
							job_width_reg <= ph_width;
							SRC_REQ <= 1'b1;
							SRC_KIND <= ph_kind;
							SRC_ADDR <= ph_addr;
							SRC_SUB <= ph_sub;
							BUSY <= 1'b1;
						end
					end else if (abs_take) begin
						if (!servo_positive || sv_kind == `PPSD_SRC_NONE) begin
							// Reference left to a homing move
							ABS_POS <= 24'h00_0000;
							ABS_VALID <= 1'b0;
						end else begin
							state_reg <= S_WAIT;
							job_abs_reg <= 1'b1;
							job_width_reg <= sv_width;
							SRC_REQ <= 1'b1;
							SRC_KIND <= sv_kind;
							SRC_ADDR <= sv_addr;
							SRC_SUB <= sv_sub;
							BUSY <= 1'b1;
						end
					end
				end
				S_WAIT: begin
					if (SRC_ACK) begin
						state_reg <= S_IDLE;
						SRC_REQ <= 1'b0;
						BUSY <= 1'b0;
						if (job_abs_reg) begin
							ABS_POS <= extract(SRC_KIND, job_width_reg, SRC_DATA);
							ABS_VALID <= 1'b1;
						end else begin
							PHASE_POS <= extract(SRC_KIND, job_width_reg, SRC_DATA);
							PHASE_VALID <= 1'b1;
							PHASE_SEARCH_REQ <= 1'b0;
						end
					end
				end
				default: begin
					state_reg <= S_IDLE;
					SRC_REQ <= 1'b0;
					BUSY <= 1'b0;
				end
			endcase
		end
	end

	// ****************************************
	// Host report format
	// ****************************************
	// Flag tells the host side to print the source word in hex
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			HEX_REPORT <= 1'b0;
		end else begin
			HEX_REPORT <= (fmt == `PPSD_FMT_HEX_A) | (fmt == `PPSD_FMT_HEX_B);
		end
	end
endmodule

`default_nettype wire

/* test/ppsd_top_monitor.sv */
// Port checker for the phase source decoder top.
// Assumes one clock domain; attached by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
`include "ppsd_consts.vh"
module ppsd_chk (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [1:0] S_AXI_BRESP,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [31:0] S_AXI_RDATA,
	input wire logic SRC_REQ,
	input wire logic [2:0] SRC_KIND,
	input wire logic [15:0] SRC_ADDR,
	input wire logic [3:0] SRC_SUB,
	input wire logic SRC_ACK,
	input wire logic [23:0] SRC_DATA,
	input wire logic [23:0] PHASE_POS,
	input wire logic BUSY
);
	// ********************
	// Checks
	// ********************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	// Both write channels taken at one edge
	sequence s_wr_taken;
		S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
	endsequence
	// Source read completes at this edge
	sequence s_src_done;
		SRC_REQ && SRC_ACK;
	endsequence
	chk_write_answer: assert property (s_wr_taken |-> ##2 S_AXI_BVALID)
		else $error("write answer late");
	chk_bresp_stand: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
		else $error("write answer dropped");
	chk_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
		else $error("read answer late");
	chk_rdata_stand: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
		else $error("read answer dropped");
	chk_req_hold: assert property (SRC_REQ && !SRC_ACK |=> SRC_REQ && $stable({SRC_KIND, SRC_ADDR, SRC_SUB}))
		else $error("source request moved");
	chk_ack_ends: assert property (s_src_done |=> !SRC_REQ && !BUSY)
		else $error("source read not closed");
	chk_kind_known: assert property (SRC_REQ |-> BUSY && SRC_KIND != `PPSD_SRC_NONE && SRC_KIND <= `PPSD_SRC_HALL)
		else $error("request with no method");
	chk_mux_port: assert property (SRC_REQ && SRC_KIND == `PPSD_SRC_MUX_RD |-> SRC_ADDR[2:0] == 3'h0 && !SRC_SUB[3])
		else $error("bad converter port");
	chk_hall_bits: assert property ((s_src_done and (SRC_KIND == `PPSD_SRC_HALL)) |=> PHASE_POS[2:0] == $past(SRC_DATA[22:20]))
		else $error("hall bits wrong");
endmodule
bind ppsd_top ppsd_chk u_chk (.*);
`default_nettype wire

/* test/ppsd_src_model.sv */
// Model of the position sources behind the read port.
// Assumes the requester holds its request until the acknowledge.
`timescale 1ns/100ps
`default_nettype none
module ppsd_src_model #(
	parameter logic [23:0] SAMPLE = 24'hD5_B3C6
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic [3:0] delay,
	output logic ack,
	output logic [23:0] data
);
	logic [3:0] wait_reg;
	// Answer after delay cycles; data toggles otherwise so a stale word never passes
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			wait_reg <= 4'h0;
			data <= ~SAMPLE;
		end else if (req && !ack && wait_reg == delay) begin
			ack <= 1'b1;
			wait_reg <= 4'h0;
			data <= SAMPLE;
		end else begin
			ack <= 1'b0;
			wait_reg <= (req && !ack) ? wait_reg + 4'h1 : 4'h0;
			data <= ~data;
		end
	end
endmodule
`default_nettype wire

/* test/tb_power_on_phase_position_source_decoder.sv */
// Bench for the phase source decoder top.
// Assumes the source model on the read port and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb_power_on_phase_position_source_decoder;
	localparam logic [23:0] SAMPLE = 24'hD5_B3C6;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] dly = 4'h0;
	wire logic awready, wready, bvalid, arready, rvalid, req, ack, pv, srch, av, hexr, busy;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0] kind;
	wire logic [15:0] addr;
	wire logic [3:0] sub;
	wire logic [23:0] sdata, ppos, apos;
	int mismatches = 0, n_checks = 0, cycles = 0, lag = 0;
	logic [31:0] d;
	logic [1:0] r;
	always #5 clk = ~clk;
	ppsd_top dut_u (.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SRC_REQ(req), .SRC_KIND(kind),
		.SRC_ADDR(addr), .SRC_SUB(sub), .SRC_ACK(ack), .SRC_DATA(sdata), .PHASE_POS(ppos), .PHASE_VALID(pv),
		.PHASE_SEARCH_REQ(srch), .ABS_POS(apos), .ABS_VALID(av), .HEX_REPORT(hexr), .BUSY(busy));
	ppsd_src_model #(.SAMPLE(SAMPLE)) src_u (.clk(clk), .rst_n(rst_n), .req(req), .delay(dly), .ack(ack),
		.data(sdata));
	// ********************
	// Bus and compare helpers
	// ********************
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Offer address and data together; release each once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
		bit aw_done = 1'b0;
		bit w_done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= (lag == 0);
		while (!(aw_done && w_done)) begin
			@(posedge clk);
			aw_done |= awready;
			w_done |= wready;
			awvalid <= !aw_done;
			wvalid <= !w_done;
		end
		repeat (lag) @(posedge clk);
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (lag == 0);
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		repeat (lag) @(posedge clk);
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		axi_wr(a, v, r);
		chk("bresp", 32'h0000_0000, r);
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
		axi_rd(a, d, r);
		chk(what, e, d);
	endtask
	// Bounded wait of up to 30 cycles for a source request; completion is left to the caller
	task automatic wait_req;
		int n = 0;
		while (!req && n < 30) begin
			@(posedge clk);
			n++;
		end
		chk("request", 32'h0000_0001, req);
	endtask
	function automatic logic [23:0] exp_pos(input logic [23:0] w, input logic [2:0] k);
		if (k == 3'h6) return {21'h0, SAMPLE[22:20]};
		if (k == 3'h2 || k == 3'h3) return SAMPLE & (24'hFF_FFFF >> (6'd24 - w[21:16]));
		return SAMPLE;
	endfunction
	// ********************
	// Scenarios
	// ********************
	task automatic t_reset;
		rd_chk(8'h00, 32'h0000_0000, "source word");
		rd_chk(8'h04, 32'h0000_0000, "servo param");
		rd_chk(8'h08, 32'h0000_0000, "config");
		chk("search flag", 32'h0000_0001, srch);
	endtask
	// Late ready here makes the answers stand for a few cycles
	task automatic t_unmapped;
		lag = 3;
		axi_rd(8'h1C, d, r);
		chk("unmapped rresp", 32'h0000_0002, r);
		chk("unmapped rdata", 32'h0000_0000, d);
		axi_wr(8'h1C, 32'h0000_0001, r);
		chk("unmapped bresp", 32'h0000_0002, r);
		lag = 0;
	endtask
	// Every method and its boundaries; slow and prompt source answers mixed
	task automatic t_table;
		logic [23:0] w [13] = '{24'h05_0048, 24'h05_0049, 24'h00_0100, 24'h20_0000, 24'h10_C001, 24'h19_0000,
			24'h58_C001, 24'h00_0000, 24'h73_0005, 24'h74_0003, 24'h08_1234, 24'h80_C008, 24'h40_0000};
		logic [2:0] k [13] = '{3'h1, 3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h3, 3'h0, 3'h4, 3'h5, 3'h2, 3'h6, 3'h0};
		for (int i = 0; i < 13; i++) begin
			dly <= 4'(i % 3);
			wr(8'h00, {8'h00, w[i]});
			wr(8'h0C, 32'h0000_0001);
			if (k[i] == 3'h0) begin
				repeat (6) @(posedge clk);
				chk("idle request", 32'h0000_0000, req);
				chk("search flag", 32'h0000_0001, srch);
			end else begin
				wait_req();
				chk("kind", k[i], kind);
				chk("address", k[i] == 3'h1 ? w[i][7:0] : w[i][15:0], k[i] == 3'h1 ? addr[7:0] : addr);
				if (k[i] inside {3'h1, 3'h4, 3'h5}) chk("sub", k[i] == 3'h1 ? w[i][19:16] : w[i][3:0], sub);
				while (busy) @(posedge clk);
				rd_chk(8'h14, exp_pos(w[i], k[i]), "phase position");
				chk("phase valid", 32'h0000_0001, pv);
			end
			axi_rd(8'h10, d, r);
			chk("decoded kind", k[i], d[10:8]);
		end
	endtask
	task automatic t_slip;
		wr(8'h08, 32'h0000_0100);
		wr(8'h0C, 32'h0000_0001);
		repeat (6) @(posedge clk);
		chk("search with slip", 32'h0000_0000, srch);
		wr(8'h08, 32'h0000_0000);
	endtask
	task automatic t_hex;
		for (int f = 0; f < 4; f++) begin
			wr(8'h08, 32'(f) << 4);
			chk("hex report", f >= 2, hexr);
		end
		wr(8'h08, 32'hFFFF_FF30);
		rd_chk(8'h08, 32'h0000_0F30, "config width");
		wr(8'h08, 32'h0000_0000);
	endtask
	// Zero parameter homes; nonzero reads, and a second command reads again
	task automatic t_abs;
		wr(8'h04, 32'h0000_0000);
		wr(8'h0C, 32'h0000_0002);
		repeat (6) @(posedge clk);
		chk("abs idle request", 32'h0000_0000, req);
		chk("abs position", 32'h0000_0000, apos);
		wr(8'h04, 32'h0010_C001);
		dly <= 4'h5;
		repeat (2) begin
			wr(8'h0C, 32'h0000_0002);
			wait_req();
			chk("abs kind", 32'h0000_0002, kind);
			while (busy) @(posedge clk);
			@(posedge clk);
			chk("abs position", 32'h0000_B3C6, apos);
			chk("abs valid", 32'h0000_0001, av);
		end
		rd_chk(8'h18, 32'h0000_B3C6, "abs register");
	endtask
	task automatic report_and_stop;
		if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Main sequence after a 16-cycle reset
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_unmapped();
		t_table();
		t_slip();
		t_hex();
		t_abs();
		report_and_stop();
	end
	// Hang guard: the whole run needs far fewer cycles than this
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches++;
			report_and_stop();
		end
	end
endmodule
`default_nettype wire
